// File: design/rst_seq_pkg.sv
// constants, encodings and state codes for the reset initialisation sequencer
// assumes one free-running clock; output hold, hard-to-soft gap and input filter counts double in host mode with the divider set
package rst_seq_pkg;

	// ---------------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS     = 8;
	localparam int unsigned IN_ASSERT_MIN     = 32;
	localparam int unsigned POR_ASSERT_MIN    = 32;
	localparam int unsigned OUT_ASSERT_MIN    = 512;
	localparam int unsigned HARD_TO_SOFT_MIN  = 16;
	localparam int unsigned CFG_SETUP_MIN     = 4;
	localparam int unsigned CFG_OFF_MAX_NS    = 4;
	// a longest time rounds down but never below one cycle
	localparam int unsigned CFG_OFF_MAX_CYC   =
		(CFG_OFF_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : (CFG_OFF_MAX_NS / CLK_PERIOD_NS);
	localparam int unsigned CFG_REDRIVE_MIN   = 1;
	localparam int unsigned DLL_LOCK_MIN_CYC  = 7680;
	localparam int unsigned DLL_LOCK_MAX_CYC  = 122880;
	localparam int unsigned DLL_RATIO_MIN     = 2;
	localparam int unsigned DLL_RATIO_MAX     = 8;

	// ---------------------------------------------------------------
	// widths and configuration layout
	// ---------------------------------------------------------------
	localparam int unsigned CNT_W             = 17;
	localparam int unsigned FILT_W            = 8;
	localparam int unsigned RATIO_W           = 4;
	localparam int unsigned CFG_W             = 4;
	localparam int unsigned CFG_SRC_LSB       = 0;
	localparam int unsigned CFG_SRC_W         = 3;
	localparam int unsigned CFG_DIV_BIT       = 3;
	localparam logic [CFG_W-1:0] CFG_RESET    = 4'h0;

	// ---------------------------------------------------------------
	// sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_POR   = 6'h01,
		ST_HARD  = 6'h02,
		ST_SOFT  = 6'h04,
		ST_DLL   = 6'h08,
		ST_RUN   = 6'h10,
		ST_SONLY = 6'h20
	} seq_state_type;

endpackage : rst_seq_pkg

// File: design/reset_pin_filter.sv
// synchroniser and consecutive-low counter for one active-low reset input
// assumes the pin may be asynchronous to mclk_in; threshold is stable while counting
module reset_pin_filter #(
	parameter int unsigned CNT_W = 8
) (
	// clock and reset
	input  wire logic             mclk_in,
	input  wire logic             rst_n_in,
	// pin side
	input  wire logic             pin_n_in,
	input  wire logic [CNT_W-1:0] thresh_in,
	// results
	output logic                  level_n_out,
	output logic                  accept_out
);

	logic             sync1_r;
	logic             sync2_r;
	logic [CNT_W-1:0] run_r;
	logic [CNT_W-1:0] run_nxt;
	logic             accept_r;
	logic             accept_nxt;
	wire  logic       run_full_w;

	assign run_full_w  = (run_r >= thresh_in);
	assign run_nxt     = sync2_r ? '0 : (run_full_w ? run_r : run_r + CNT_W'(1));
	// accepted once the low level has been seen on thresh consecutive edges
	assign accept_nxt  = !sync2_r && (run_r >= thresh_in - CNT_W'(1));
	assign level_n_out = sync2_r;
	assign accept_out  = accept_r;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync1_r  <= 1'b1;
			sync2_r  <= 1'b1;
			run_r    <= '0;
			accept_r <= 1'b0;
		end else begin
			sync1_r  <= pin_n_in;
			sync2_r  <= sync1_r;
			run_r    <= run_nxt;
			accept_r <= accept_nxt;
		end
	end

	// request only after a low synchronised sample on the previous edge
	a_accept_run : assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		accept_r |-> $past(!sync2_r)) else $error("accept without low input");

endmodule : reset_pin_filter

// File: design/reset_init_sequencer.sv
// reset initialisation sequencer: filters reset inputs, drives open-drain reset lines,
// orders hard and soft release, captures power-on straps and waits for delay-line lock
// assumes all pins are sampled on mclk_in; the board pulls the reset lines high
module reset_init_sequencer #(
	parameter int unsigned DLL_LOCK_MIN = rst_seq_pkg::DLL_LOCK_MIN_CYC,
	parameter int unsigned DLL_LOCK_MAX = rst_seq_pkg::DLL_LOCK_MAX_CYC
) (
	// clock and reset
	input  wire logic                              mclk_in,
	input  wire logic                              rst_n_in,
	// mode and clock ratio
	input  wire logic                              host_mode_in,
	input  wire logic [rst_seq_pkg::RATIO_W-1:0]   dll_ratio_in,
	// power-on reset
	input  wire logic                              power_on_reset_n_in,
	// hard reset line, open drain
	input  wire logic                              hard_reset_line_n_in,
	output logic                                   hard_reset_line_n_out,
	output logic                                   hard_reset_line_oe_out,
	// soft reset line, open drain
	input  wire logic                              soft_reset_line_n_in,
	output logic                                   soft_reset_line_n_out,
	output logic                                   soft_reset_line_oe_out,
	// power-on configuration pins
	input  wire logic [rst_seq_pkg::CFG_W-1:0]     cfg_pins_in,
	output logic [rst_seq_pkg::CFG_W-1:0]          cfg_pins_out,
	output logic                                   cfg_pins_oe_out,
	// captured configuration and status
	output logic [rst_seq_pkg::CFG_SRC_W-1:0]      reset_source_select_out,
	output logic                                   input_clock_divide_select_out,
	output logic                                   core_ready_out
);

	localparam int unsigned CW = rst_seq_pkg::CNT_W;
	localparam int unsigned FW = rst_seq_pkg::FILT_W;

	// ---------------------------------------------------------------
	// cycle arithmetic
	// ---------------------------------------------------------------
	// sync period doubles with divider in host mode
	function automatic logic [CW-1:0] sync_cycles(input int unsigned n, input logic host,
		input logic div);
		logic [CW-1:0] base;
		base = CW'(n);
		sync_cycles = (host && div) ? {base[CW-2:0], 1'b0} : base;
	endfunction : sync_cycles

	// lock wait grows with ratio squared
	function automatic logic [CW-1:0] dll_cycles(input logic [rst_seq_pkg::RATIO_W-1:0] r);
		logic [rst_seq_pkg::RATIO_W-1:0] rc;
		logic [31:0]                     prod;
		rc = r;
		if (r < rst_seq_pkg::RATIO_W'(rst_seq_pkg::DLL_RATIO_MIN))
			rc = rst_seq_pkg::RATIO_W'(rst_seq_pkg::DLL_RATIO_MIN);
		if (r > rst_seq_pkg::RATIO_W'(rst_seq_pkg::DLL_RATIO_MAX))
			rc = rst_seq_pkg::RATIO_W'(rst_seq_pkg::DLL_RATIO_MAX);
		prod = (32'(DLL_LOCK_MIN) * 32'(rc) * 32'(rc)) >> 2;
		dll_cycles = prod[CW-1:0];
	endfunction : dll_cycles

	// ---------------------------------------------------------------
	// state and registers
	// ---------------------------------------------------------------
	rst_seq_pkg::seq_state_type state_r;
	rst_seq_pkg::seq_state_type state_nxt;
	logic [CW-1:0]                   cnt_r;
	logic [CW-1:0]                   cnt_nxt;
	logic [rst_seq_pkg::CFG_W-1:0]   cfg_r;
	logic                            hard_oe_r;
	logic                            soft_oe_r;
	logic                            cfg_oe_r;
	logic                            hard_rel_r;
	logic                            ready_r;
	logic                            por_acc;
	logic                            por_lvl_n;
	logic                            hard_acc;
	logic                            hard_lvl_n;
	logic                            soft_acc;
	logic                            soft_lvl_n;

	wire logic          div_sel_w   = cfg_r[rst_seq_pkg::CFG_DIV_BIT];
	wire logic          st_por_w    = (state_r == rst_seq_pkg::ST_POR);
	wire logic          capture_w   = st_por_w && por_lvl_n;
	wire logic [CW-1:0] out_hold_w  = sync_cycles(rst_seq_pkg::OUT_ASSERT_MIN, host_mode_in,
		capture_w ? cfg_pins_in[rst_seq_pkg::CFG_DIV_BIT] : div_sel_w) - CW'(1);
	wire logic [CW-1:0] gap_hold_w  = sync_cycles(rst_seq_pkg::HARD_TO_SOFT_MIN,
		host_mode_in, div_sel_w) - CW'(1);
	wire logic [CW-1:0] in_thr_w    = sync_cycles(rst_seq_pkg::IN_ASSERT_MIN, host_mode_in,
		div_sel_w);
	wire logic [FW-1:0] in_thr_f_w  = in_thr_w[FW-1:0];
	wire logic [FW-1:0] por_thr_w   = FW'(rst_seq_pkg::POR_ASSERT_MIN);
	wire logic          cnt_done_w  = (cnt_r == '0);
	wire logic          st_hard_w   = (state_r == rst_seq_pkg::ST_HARD);

	// ---------------------------------------------------------------
	// input filters
	// ---------------------------------------------------------------
	// own drive is or-ed in so the sequencer never answers its own assertion
	reset_pin_filter #(.CNT_W(FW)) u_por_filt (
		.mclk_in     (mclk_in),
		.rst_n_in    (rst_n_in),
		.pin_n_in    (power_on_reset_n_in),
		.thresh_in   (por_thr_w),
		.level_n_out (por_lvl_n),
		.accept_out  (por_acc)
	);

	reset_pin_filter #(.CNT_W(FW)) u_hard_filt (
		.mclk_in     (mclk_in),
		.rst_n_in    (rst_n_in),
		.pin_n_in    (hard_reset_line_n_in | hard_oe_r),
		.thresh_in   (in_thr_f_w),
		.level_n_out (hard_lvl_n),
		.accept_out  (hard_acc)
	);

	reset_pin_filter #(.CNT_W(FW)) u_soft_filt (
		.mclk_in     (mclk_in),
		.rst_n_in    (rst_n_in),
		.pin_n_in    (soft_reset_line_n_in | soft_oe_r),
		.thresh_in   (in_thr_f_w),
		.level_n_out (soft_lvl_n),
		.accept_out  (soft_acc)
	);

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_done_w ? cnt_r : cnt_r - CW'(1);
		unique case (state_r)
			rst_seq_pkg::ST_POR: begin
				if (por_lvl_n) begin
					state_nxt = rst_seq_pkg::ST_HARD;
					cnt_nxt   = out_hold_w;
				end
			end
			rst_seq_pkg::ST_HARD: begin
				if (cnt_done_w) begin
					state_nxt = rst_seq_pkg::ST_SOFT;
					cnt_nxt   = gap_hold_w;
				end
			end
			rst_seq_pkg::ST_SOFT: begin
				if (cnt_done_w) begin
					state_nxt = rst_seq_pkg::ST_DLL;
					cnt_nxt   = dll_cycles(dll_ratio_in) - CW'(1);
				end
			end
			rst_seq_pkg::ST_DLL, rst_seq_pkg::ST_RUN: begin
				if (state_r == rst_seq_pkg::ST_DLL && cnt_done_w)
					state_nxt = rst_seq_pkg::ST_RUN;
				if (hard_acc) begin
					state_nxt = rst_seq_pkg::ST_HARD;
					cnt_nxt   = out_hold_w;
				end else if (soft_acc) begin
					state_nxt = rst_seq_pkg::ST_SONLY;
					cnt_nxt   = out_hold_w;
				end
			end
			rst_seq_pkg::ST_SONLY: begin
				if (hard_acc) begin
					state_nxt = rst_seq_pkg::ST_HARD;
					cnt_nxt   = out_hold_w;
				end else if (cnt_done_w) begin
					state_nxt = rst_seq_pkg::ST_RUN;
				end
			end
			default: begin
				state_nxt = rst_seq_pkg::ST_POR;
			end
		endcase
		if (por_acc) begin
			state_nxt = rst_seq_pkg::ST_POR;
			cnt_nxt   = '0;
		end
	end

	// straps released whenever hard is low
	// a pin-originated hard reset is seen two edges late through the synchroniser
	wire logic hard_oe_nxt = (state_nxt == rst_seq_pkg::ST_POR) ||
		(state_nxt == rst_seq_pkg::ST_HARD);
	wire logic soft_oe_nxt = hard_oe_nxt || (state_nxt == rst_seq_pkg::ST_SOFT) ||
		(state_nxt == rst_seq_pkg::ST_SONLY);
	// two idle clock periods after hard release
	wire logic cfg_oe_nxt  = !hard_oe_nxt && hard_rel_r && !hard_oe_r && hard_lvl_n;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r    <= rst_seq_pkg::ST_POR;
			cnt_r      <= '0;
			hard_oe_r  <= 1'b1;
			soft_oe_r  <= 1'b1;
			cfg_oe_r   <= 1'b0;
			hard_rel_r <= 1'b0;
			ready_r    <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			cnt_r      <= cnt_nxt;
			hard_oe_r  <= hard_oe_nxt;
			soft_oe_r  <= soft_oe_nxt;
			cfg_oe_r   <= cfg_oe_nxt;
			hard_rel_r <= !hard_oe_r;
			ready_r    <= (state_nxt == rst_seq_pkg::ST_RUN);
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_r <= rst_seq_pkg::CFG_RESET;
		end else if (capture_w) begin
			cfg_r <= cfg_pins_in;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// lines only ever pulled low
	assign hard_reset_line_n_out         = 1'b0;
	assign soft_reset_line_n_out         = 1'b0;
	assign hard_reset_line_oe_out        = hard_oe_r;
	assign soft_reset_line_oe_out        = soft_oe_r;
	assign cfg_pins_oe_out               = cfg_oe_r;
	assign cfg_pins_out                  = cfg_r;
	// three source bits, one divider bit
	assign reset_source_select_out       =
		cfg_r[rst_seq_pkg::CFG_SRC_LSB +: rst_seq_pkg::CFG_SRC_W];
	assign input_clock_divide_select_out = div_sel_w;
	assign core_ready_out                = ready_r;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	logic [CW-1:0] hard_run_r;
	logic [CW-1:0] gap_run_r;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hard_run_r <= '0;
			gap_run_r  <= '0;
		end else begin
			hard_run_r <= (hard_oe_nxt && !hard_oe_r) ? '0 :
				(hard_oe_r ? hard_run_r + CW'(1) : hard_run_r);
			gap_run_r  <= hard_oe_r ? '0 : (soft_oe_r ? gap_run_r + CW'(1) : gap_run_r);
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	a_hard_hold_min : assert property ($fell(hard_oe_r) |->
		hard_run_r >= CW'(rst_seq_pkg::OUT_ASSERT_MIN)) else $error("hard reset too short");
	a_soft_gap_min : assert property ($fell(soft_oe_r) && $past(state_r) ==
		rst_seq_pkg::ST_SOFT |-> gap_run_r >= CW'(rst_seq_pkg::HARD_TO_SOFT_MIN))
		else $error("soft released too soon after hard");
	a_cfg_off_hard : assert property (hard_oe_r |-> !cfg_oe_r)
		else $error("strap pins driven during hard reset");
	a_cfg_redrive : assert property ($rose(cfg_oe_r) |->
		!hard_oe_r && $past(!hard_oe_r) && $past(!hard_oe_r, 2))
		else $error("straps redriven too early");
	a_low_only : assert property (!hard_reset_line_n_out && !soft_reset_line_n_out)
		else $error("reset line driven high");
	a_cfg_hold : assert property (!st_por_w |=> $stable(cfg_r))
		else $error("straps changed outside power-on");
	a_dll_range : assert property ($rose(state_r == rst_seq_pkg::ST_DLL) |->
		cnt_r >= CW'(DLL_LOCK_MIN - 1) && cnt_r <= CW'(DLL_LOCK_MAX - 1))
		else $error("lock wait out of range");
	a_div_scale : assert property (host_mode_in && div_sel_w |->
		in_thr_w == CW'(2 * rst_seq_pkg::IN_ASSERT_MIN)) else $error("host divider ignored");
	a_agent_direct : assert property (!host_mode_in |->
		in_thr_w == CW'(rst_seq_pkg::IN_ASSERT_MIN)) else $error("agent count scaled");
	a_ext_hard : assert property (hard_acc && !por_acc &&
		state_r == rst_seq_pkg::ST_RUN |=> st_hard_w && hard_oe_r)
		else $error("accepted hard request ignored");

	c_reach_run  : cover property ($rose(core_ready_out));
	c_ext_hard   : cover property (state_r == rst_seq_pkg::ST_RUN && hard_acc);
	c_soft_only  : cover property ($fell(soft_oe_r) && $past(state_r) == rst_seq_pkg::ST_SONLY);
	c_cfg_driven : cover property ($rose(cfg_oe_r));

endmodule : reset_init_sequencer

// File: tb/board_reset_model.sv
// board side of the reset pins: supervisor, an outside agent on the shared lines, strap resistors
// assumes the bench resolves the open-drain lines with pull-ups and lets straps lose to the device
module board_reset_model (
	// clock
	input  wire logic                          mclk_in,
	// board drives
	output logic                               power_on_reset_n_out,
	output logic                               hard_pull_out,
	output logic                               soft_pull_out,
	output logic [rst_seq_pkg::CFG_W-1:0]      strap_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// twice the minimum lead, so a late capture in the device still sees settled straps
	localparam int unsigned STRAP_LEAD = 2 * rst_seq_pkg::CFG_SETUP_MIN;

	initial begin
		power_on_reset_n_out = 1'b0;
		hard_pull_out        = 1'b0;
		soft_pull_out        = 1'b0;
		strap_out            = 4'h0;
	end

	// ---------------------------------------------------------------
	// supervisor
	// ---------------------------------------------------------------
	// power-on hold
	task automatic power_on(input logic [3:0] straps, input int hold);
		@(negedge mclk_in);
		power_on_reset_n_out = 1'b0;
		repeat (hold) @(negedge mclk_in);
		strap_out = straps;
		repeat (STRAP_LEAD) @(negedge mclk_in);
		power_on_reset_n_out = 1'b1;
	endtask : power_on

	// ---------------------------------------------------------------
	// outside agent on the shared lines
	// ---------------------------------------------------------------
	// line held low
	// span below the minimum is used on purpose to see a refusal
	task automatic pull_line(input logic hard, input int span);
		@(negedge mclk_in);
		hard_pull_out = hard;
		soft_pull_out = ~hard;
		repeat (span) @(negedge mclk_in);
		hard_pull_out = 1'b0;
		soft_pull_out = 1'b0;
	endtask : pull_line

endmodule : board_reset_model

// File: tb/reset_init_sequencer_tb.sv
// self-checking bench for the reset initialisation sequencer
// assumes a shortened lock wait (minimum 8) and pull-ups on both reset lines
module reset_init_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;

`define CHK(what, exp, got) \
	begin n_checks++; if ((got) !== (exp)) begin failures++; \
	$display("BAD %s expected %0h seen %0h", what, exp, got); end end

	typedef struct {
		logic       host;
		logic [3:0] straps;
		logic [3:0] ratio;
		int         scale;
		int         lock;
	} row_type;

	localparam int HOLD = rst_seq_pkg::OUT_ASSERT_MIN;
	localparam int LAG  = rst_seq_pkg::HARD_TO_SOFT_MIN;

	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic       mclk;
	logic       rst_n;
	logic       host_mode;
	logic [3:0] dll_ratio;
	logic       por_n;
	logic       hard_pull;
	logic       soft_pull;
	logic [3:0] strap;
	logic       hard_n_out;
	logic       hard_oe;
	logic       soft_n_out;
	logic       soft_oe;
	logic [3:0] cfg_out;
	logic       cfg_oe;
	logic [2:0] src;
	logic       div_sel;
	logic       ready;
	int         failures;
	int         n_checks;
	int         cnt;

	wire logic       hard_line_n = (hard_oe ? hard_n_out : 1'b1) & ~hard_pull;
	wire logic       soft_line_n = (soft_oe ? soft_n_out : 1'b1) & ~soft_pull;
	wire logic [3:0] cfg_pin     = cfg_oe ? cfg_out : strap;
	wire logic [3:0] mon         = {cfg_oe, ready, soft_oe, hard_oe};

	// scale 2 only for host mode with the divider strap set; ratio 1 and 15 clamp
	row_type rows [5] = '{
		'{1'b1, 4'ha, 4'h4, 2, 32},
		'{1'b1, 4'h3, 4'h1, 1, 8},
		'{1'b0, 4'hb, 4'h8, 1, 128},
		'{1'b1, 4'hc, 4'hf, 2, 128},
		'{1'b0, 4'h5, 4'h2, 1, 8}
	};

	// ---------------------------------------------------------------
	// design and board
	// ---------------------------------------------------------------
	reset_init_sequencer #(.DLL_LOCK_MIN(8), .DLL_LOCK_MAX(128)) reset_init_sequencer_inst (
		.mclk_in                       (mclk),
		.rst_n_in                      (rst_n),
		.host_mode_in                  (host_mode),
		.dll_ratio_in                  (dll_ratio),
		.power_on_reset_n_in           (por_n),
		.hard_reset_line_n_in          (hard_line_n),
		.hard_reset_line_n_out         (hard_n_out),
		.hard_reset_line_oe_out        (hard_oe),
		.soft_reset_line_n_in          (soft_line_n),
		.soft_reset_line_n_out         (soft_n_out),
		.soft_reset_line_oe_out        (soft_oe),
		.cfg_pins_in                   (cfg_pin),
		.cfg_pins_out                  (cfg_out),
		.cfg_pins_oe_out               (cfg_oe),
		.reset_source_select_out       (src),
		.input_clock_divide_select_out (div_sel),
		.core_ready_out                (ready)
	);

	board_reset_model model_inst (
		.mclk_in              (mclk),
		.power_on_reset_n_out (por_n),
		.hard_pull_out        (hard_pull),
		.soft_pull_out        (soft_pull),
		.strap_out            (strap)
	);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// counts clock edges until one bit of mon reaches val; a miss counts as a mismatch
	task automatic wait_bit(input int idx, input logic val, input int limit, output int n);
		n = 0;
		while (mon[idx] !== val && n < limit) begin
			@(posedge mclk);
			#1;
			n++;
		end
		`CHK("awaited bit", val, mon[idx])
	endtask : wait_bit

	task automatic wrap_up;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : wrap_up

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	initial begin
		#(8 * 30000);
		failures++;
		wrap_up();
	end

	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		failures  = 0;
		n_checks  = 0;
		rst_n     = 1'b0;
		host_mode = 1'b0;
		dll_ratio = 4'h2;
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		foreach (rows[i]) begin
			@(negedge mclk);
			host_mode = rows[i].host;
			dll_ratio = rows[i].ratio;
			model_inst.power_on(rows[i].straps, 64);
			`CHK("cfg oe held", 1'b0, cfg_oe)
			`CHK("hard level", 1'b0, hard_n_out)
			`CHK("soft level", 1'b0, soft_n_out)
			wait_bit(0, 1'b0, 2000, cnt);
			`CHK("hard hold", 1'b1, cnt >= HOLD * rows[i].scale && cnt <= HOLD * rows[i].scale + 8)
			wait_bit(1, 1'b0, 100, cnt);
			`CHK("soft lag", 1'b1, cnt >= LAG * rows[i].scale && cnt <= LAG * rows[i].scale + 1)
			`CHK("cfg redriven", 1'b1, cfg_oe)
			`CHK("cfg pin", rows[i].straps, cfg_pin)
			`CHK("source", rows[i].straps[2:0], src)
			`CHK("divider", rows[i].straps[3], div_sel)
			wait_bit(2, 1'b1, 300, cnt);
			`CHK("lock wait", 1'b1, cnt >= rows[i].lock && cnt <= rows[i].lock + 2)
		end
		// one edge short of the filter count: nothing may happen
		model_inst.pull_line(1'b1, 31);
		repeat (40) @(negedge mclk);
		`CHK("short pulse", 3'b001, {hard_oe, soft_oe, ready})
		model_inst.pull_line(1'b1, 33);
		wait_bit(0, 1'b1, 8, cnt);
		`CHK("ext hard", 3'b001, {cfg_oe, ready, soft_oe})
		wait_bit(0, 1'b0, 600, cnt);
		`CHK("ext hold", 1'b1, cnt >= HOLD && cnt <= HOLD + 2)
		wait_bit(1, 1'b0, 40, cnt);
		`CHK("ext lag", 1'b1, cnt >= LAG && cnt <= LAG + 1)
		wait_bit(2, 1'b1, 40, cnt);
		model_inst.pull_line(1'b0, 33);
		wait_bit(1, 1'b1, 8, cnt);
		wait_bit(1, 1'b0, 600, cnt);
		`CHK("soft hold", 1'b1, cnt >= HOLD && cnt <= HOLD + 2)
		`CHK("hard idle", 1'b0, hard_oe)
		// reset in mid-run with power-on already high
		@(negedge mclk);
		rst_n = 1'b0;
		#1;
		`CHK("reset outs", {4'b1100, 3'h0}, {hard_oe, soft_oe, cfg_oe, ready, src})
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		wait_bit(0, 1'b0, 700, cnt);
		wait_bit(2, 1'b1, 100, cnt);
		`CHK("recaptured", 3'h5, src)
		wrap_up();
	end

endmodule : reset_init_sequencer_tb
